// File: src/utdc_ctrl.sv
// upstream transmitter disable message handler, top level
`timescale 1ns/1ps

module utdc_ctrl
    import utdc_pkg::*;
#(
    // last count of the ms tick; a short tick lets expiry be reached quickly
    parameter logic [TICK_CNT_W-1:0] TICK_LAST_CFG = TICK_LAST
)
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire utdc_msg_t  msgIn,
    input  wire logic       upstreamReq,
    output utdc_ctrl_t      ctrlOut,
    output logic            upstreamGrant
);

    typedef struct packed {
        utdc_state_t mode;
        utdc_ctrl_t  ctrl;
        logic        grant;
    } utdc_top_t;

    utdc_top_t state_reg;
    utdc_top_t state_next;

    logic msgHit;
    logic isPerm;
    logic isReen;
    logic timerLoad;
    logic timerExpired;

    // message accepted at any cycle, no prior handshake needed
    assign msgHit = msgIn.valid
                    && (msgIn.unicastHit || msgIn.multicastHit);
    assign isPerm = msgIn.disableTimeoutMs == TIMEOUT_PERMANENT;
    assign isReen = msgIn.disableTimeoutMs == TIMEOUT_REENABLE;

    assign timerLoad = msgHit && !isPerm && !isReen
                       && state_reg.mode == ST_ENABLED;

    utdc_ms_timer #(
        .TICK_LAST_CFG (TICK_LAST_CFG)
    ) u_timer (
        .clk       (clk),
        .reset_n   (reset_n),
        .load      (timerLoad),
        .loadValue (msgIn.disableTimeoutMs),
        .run       (state_reg.mode == ST_TIMED),
        .expired   (timerExpired)
    );

    always_comb
    begin
        state_next = state_reg;
        state_next.ctrl.txReset   = 1'b0;
        state_next.ctrl.macReinit = 1'b0;
        case (state_reg.mode)
            ST_ENABLED:
            begin
                if (msgHit && isPerm)
                begin
                    state_next.mode = ST_PERMANENT;
                end
                else if (msgHit && isReen)
                begin
                    state_next.ctrl.txReset   = 1'b1;
                    state_next.ctrl.macReinit = 1'b1;
                end
                else if (msgHit)
                begin
                    state_next.mode = ST_TIMED;
                end
            end
            ST_PERMANENT:
            begin
                // anything but all-ones is dropped here
                if (msgHit && isReen)
                begin
                    state_next.mode           = ST_ENABLED;
                    state_next.ctrl.txReset   = 1'b1;
                    state_next.ctrl.macReinit = 1'b1;
                end
            end
            ST_TIMED:
            begin
                if (msgHit && isPerm)
                begin
                    state_next.mode = ST_PERMANENT;
                end
                else if (msgHit && isReen)
                begin
                    state_next.mode           = ST_ENABLED;
                    state_next.ctrl.txReset   = 1'b1;
                    state_next.ctrl.macReinit = 1'b1;
                end
                else if (timerExpired)
                begin
                    state_next.mode           = ST_ENABLED;
                    state_next.ctrl.macReinit = 1'b1;
                end
            end
            default:
            begin
                state_next.mode = ST_ENABLED;
            end
        endcase
        state_next.ctrl.permDisabled  = state_next.mode == ST_PERMANENT;
        state_next.ctrl.timedDisabled = state_next.mode == ST_TIMED;
        // gate all upstream traffic; downstream path is untouched
        state_next.ctrl.txEnable = state_next.mode == ST_ENABLED;
        state_next.grant = upstreamReq
                           && state_next.mode == ST_ENABLED;
        // no reply path exists: this block never originates upstream
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // power-up clears any disabled condition
            state_reg.mode          <= ST_ENABLED;
            state_reg.ctrl.txEnable <= 1'b1;
            state_reg.ctrl.txReset  <= 1'b0;
            state_reg.ctrl.macReinit     <= 1'b0;
            state_reg.ctrl.permDisabled  <= 1'b0;
            state_reg.ctrl.timedDisabled <= 1'b0;
            state_reg.grant         <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign ctrlOut       = state_reg.ctrl;
    assign upstreamGrant = state_reg.grant;

endmodule : utdc_ctrl

// File: src/utdc_pkg.sv
// shared constants and carrier types for the upstream disable handler
package utdc_pkg;

    localparam int unsigned CLK_FREQ_HZ    = 200000000;
    localparam int unsigned TICK_PERIOD_MS = 1;
    // cycles per millisecond tick derived from the clock rate
    localparam int unsigned TICK_CYCLES    =
        (CLK_FREQ_HZ / 1000) * TICK_PERIOD_MS;
    localparam int unsigned TICK_CNT_W     = 18;
    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(TICK_CYCLES - 1);
    localparam logic [TICK_CNT_W-1:0] TICK_ZERO = 18'h00000;

    localparam int unsigned TIMEOUT_W      = 32;
    localparam logic [TIMEOUT_W-1:0] TIMEOUT_PERMANENT = 32'h00000000;
    localparam logic [TIMEOUT_W-1:0] TIMEOUT_REENABLE  = 32'hFFFFFFFF;
    localparam logic [TIMEOUT_W-1:0] TIMEOUT_ONE       = 32'h00000001;

    // incoming upstream_disable_message, already parsed from the MAC frame
    typedef struct packed {
        logic                 valid;
        logic                 unicastHit;
        logic                 multicastHit;
        logic [TIMEOUT_W-1:0] disableTimeoutMs;
    } utdc_msg_t;

    typedef enum logic [2:0] {
        ST_ENABLED   = 3'b001,
        ST_PERMANENT = 3'b010,
        ST_TIMED     = 3'b100
    } utdc_state_t;

    // tell the MAC what to do with the upstream
    typedef struct packed {
        logic txEnable;
        logic txReset;
        logic macReinit;
        logic permDisabled;
        logic timedDisabled;
    } utdc_ctrl_t;

endpackage : utdc_pkg

// File: src/utdc_ms_timer.sv
// millisecond tick and 32-bit disable down-counter
`timescale 1ns/1ps
module utdc_ms_timer
    import utdc_pkg::*;
#(
    parameter logic [TICK_CNT_W-1:0] TICK_LAST_CFG = TICK_LAST
)
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 load,
    input  wire logic [TIMEOUT_W-1:0] loadValue,
    input  wire logic                 run,
    output logic                      expired
);

    typedef struct packed {
        logic [TICK_CNT_W-1:0] tick;
        logic [TIMEOUT_W-1:0]  msLeft;
        logic                  expired;
    } utdc_tmr_t;

    utdc_tmr_t state_reg;
    utdc_tmr_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.expired = 1'b0;
        if (load)
        begin
            // tick restarts so the period is never short; expiry comes one cycle after loadValue ms
            state_next.tick   = TICK_ZERO;
            state_next.msLeft = loadValue;
        end
        else if (run)
        begin
            if (state_reg.tick == TICK_LAST_CFG)
            begin
                state_next.tick = TICK_ZERO;
                if (state_reg.msLeft == TIMEOUT_ONE)
                begin
                    state_next.msLeft  = TIMEOUT_PERMANENT;
                    state_next.expired = 1'b1;
                end
                else if (state_reg.msLeft != TIMEOUT_PERMANENT)
                begin
                    state_next.msLeft = state_reg.msLeft - TIMEOUT_ONE;
                end
            end
            else
            begin
                state_next.tick = state_reg.tick + TICK_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign expired = state_reg.expired;

endmodule : utdc_ms_timer

// File: test/utdc_ctrl_asserts.sv
// port assertions for the upstream disable handler
`timescale 1ns/1ps
module utdc_ctrl_asserts
    import utdc_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire utdc_msg_t  msgIn,
    input wire logic       upstreamReq,
    input wire utdc_ctrl_t ctrlOut,
    input wire logic       upstreamGrant
);
    logic        tk;
    logic [31:0] tv;
    logic        plain;
    logic        reenTk;
    assign tk = msgIn.valid && (msgIn.unicastHit || msgIn.multicastHit);
    assign reenTk = tk && tv == TIMEOUT_REENABLE;
    assign tv = msgIn.disableTimeoutMs;
    assign plain = tv != TIMEOUT_PERMANENT && tv != TIMEOUT_REENABLE;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence reen_s;
        ctrlOut.txEnable && ctrlOut.txReset && ctrlOut.macReinit;
    endsequence
    sequence quiet_s;
        !ctrlOut.txReset && !ctrlOut.macReinit;
    endsequence
    perm_off_a: assert property (tk && tv == TIMEOUT_PERMANENT
        |=> !ctrlOut.txEnable && ctrlOut.permDisabled)
        else $error("zero timeout not acted on");
    reen_pulse_a: assert property (reenTk |=> reen_s)
        else $error("re-enable pulses wrong");
    reen_end_a: assert property (reenTk ##1 !reenTk |=> quiet_s)
        else $error("re-enable pulses too long");
    timed_exit_a: assert property (ctrlOut.timedDisabled
        ##1 (!ctrlOut.timedDisabled && ctrlOut.txEnable)
        |-> ctrlOut.macReinit)
        else $error("timed exit without reinit");
    perm_hold_a: assert property (ctrlOut.permDisabled && tk
        && tv != TIMEOUT_REENABLE |=> ctrlOut.permDisabled)
        else $error("permanent disable left");
    timed_on_a: assert property (ctrlOut.txEnable && tk && plain
        |=> ctrlOut.timedDisabled && !ctrlOut.txEnable)
        else $error("timed disable not entered");
    timed_ign_a: assert property (ctrlOut.timedDisabled && tk
        && plain |=> ctrlOut.timedDisabled
        || (ctrlOut.macReinit && !ctrlOut.txReset))
        else $error("timed disable disturbed");
    grant_gate_a: assert property (upstreamGrant
        |-> ctrlOut.txEnable && $past(upstreamReq))
        else $error("grant while disabled");
    perm_src_a: assert property (!tk |=> $stable(ctrlOut.permDisabled))
        else $error("permanent flag moved alone");
    pulse_src_a: assert property ($rose(ctrlOut.txReset)
        |-> $past(tk) && $past(tv) == TIMEOUT_REENABLE)
        else $error("reset pulse without cause");
endmodule : utdc_ctrl_asserts
bind utdc_ctrl utdc_ctrl_asserts u_chk (.clk(clk), .reset_n(reset_n),
    .msgIn(msgIn), .upstreamReq(upstreamReq), .ctrlOut(ctrlOut),
    .upstreamGrant(upstreamGrant));

// File: test/utdc_headend.sv
// headend model issuing disable messages
`timescale 1ns/1ps
module utdc_headend
    import utdc_pkg::*;
(
    input wire logic clk,
    output utdc_msg_t msg
);
    initial msg = '0;
    // call just after an edge; keep holds valid for a back-to-back send
    task send(input logic [TIMEOUT_W-1:0] t, input logic uni,
              input logic mul, input logic keep);
        msg <= '{1'b1, uni, mul, t};
        @(posedge clk);
        if (!keep)
            msg <= '{1'b0, ~uni, ~mul, ~t};
    endtask : send
endmodule : utdc_headend

// File: test/utdc_ctrl_tb.sv
// self-checking bench for the disable handler
`timescale 1ns/1ps
module utdc_ctrl_tb;
    import utdc_pkg::*;
    logic       clk;
    logic       reset_n;
    logic       upstreamReq;
    logic       upstreamGrant;
    utdc_msg_t  msgIn;
    utdc_ctrl_t ctrlOut;
    int         n_fail = 0;
    int         checked = 0;
    // bench tick of TB_MS cycles per ms keeps expiry inside a short run
    localparam int TB_MS = 10;
    localparam logic [TICK_CNT_W-1:0] TB_TICK_LAST =
        TICK_CNT_W'(TB_MS - 1);
    utdc_ctrl #(.TICK_LAST_CFG(TB_TICK_LAST)) u_dut (.clk(clk),
        .reset_n(reset_n), .msgIn(msgIn),
        .upstreamReq(upstreamReq), .ctrlOut(ctrlOut),
        .upstreamGrant(upstreamGrant));
    utdc_headend u_he (.clk(clk), .msg(msgIn));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task end_of_test;
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // ctrlOut then grant, sampled 1 ns after the clock edge
    task cmp(input string nm, input logic [5:0] exp);
        checked++;
        if ({ctrlOut, upstreamGrant} !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp,
                {ctrlOut, upstreamGrant});
        end
    endtask : cmp
    task t_perm;
        @(posedge clk) upstreamReq <= 1'b1;
        repeat (2) @(posedge clk);
        #1 cmp("grant", 6'h21);
        @(posedge clk) u_he.send(TIMEOUT_PERMANENT, 1'b1, 1'b0, 1'b0);
        #1 cmp("perm", 6'h04);
        @(posedge clk)
        begin
            upstreamReq <= 1'b0;
            u_he.send(32'h00000005, 1'b0, 1'b1, 1'b0);
        end
        #1 cmp("perm ign", 6'h04);
        @(posedge clk) u_he.send(TIMEOUT_REENABLE, 1'b0, 1'b1, 1'b0);
        #1 cmp("reen", 6'h38);
        @(posedge clk) #1 cmp("reen end", 6'h20);
    endtask : t_perm
    task t_timed;
        @(posedge clk) u_he.send(32'h00000003, 1'b0, 1'b1, 1'b1);
        u_he.send(32'h00000007, 1'b1, 1'b0, 1'b0);
        #1 cmp("timed", 6'h02);
        repeat (20) @(posedge clk);
        #1 cmp("timed hold", 6'h02);
        @(posedge clk) u_he.send(TIMEOUT_PERMANENT, 1'b0, 1'b1, 1'b0);
        #1 cmp("timed zero", 6'h04);
        @(posedge clk) u_he.send(TIMEOUT_REENABLE, 1'b1, 1'b0, 1'b0);
        #1 cmp("timed reen", 6'h38);
    endtask : t_timed
    task t_expire;
        int n;
        @(posedge clk) u_he.send(32'h00000002, 1'b1, 1'b0, 1'b1);
        u_he.send(32'h00000009, 1'b0, 1'b1, 1'b0);
        repeat (2 * TB_MS - 1) @(posedge clk);
        #1 cmp("expire early", 6'h02);
        n = 0;
        while (ctrlOut.macReinit !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1 n++;
        end
        cmp("expire", 6'h28);
        @(posedge clk) #1 cmp("expire end", 6'h20);
    endtask : t_expire
    task t_misc;
        @(posedge clk) u_he.send(TIMEOUT_PERMANENT, 1'b0, 1'b0, 1'b0);
        #1 cmp("no hit", 6'h20);
        @(posedge clk) u_he.send(TIMEOUT_REENABLE, 1'b1, 1'b0, 1'b0);
        #1 cmp("reen idle", 6'h38);
        @(posedge clk) u_he.send(TIMEOUT_ONE, 1'b1, 1'b0, 1'b0);
        #1 cmp("one ms", 6'h02);
        @(posedge clk) u_he.send(TIMEOUT_REENABLE, 1'b0, 1'b1, 1'b0);
        #1 cmp("timed reen", 6'h38);
        @(posedge clk) u_he.send(TIMEOUT_ONE, 1'b0, 1'b1, 1'b0);
        #1 cmp("timed again", 6'h02);
        @(posedge clk) reset_n <= 1'b0;
        @(posedge clk) #1 cmp("power", 6'h20);
        @(posedge clk) reset_n <= 1'b1;
        @(posedge clk) u_he.send(TIMEOUT_PERMANENT, 1'b1, 1'b0, 1'b0);
        #1 cmp("after power", 6'h04);
    endtask : t_misc
    initial
    begin
        #20000;
        n_fail++;
        end_of_test;
    end
    initial
    begin
        reset_n = 1'b0;
        upstreamReq = 1'b0;
        @(posedge clk);
        #1 cmp("reset", 6'h20);
        @(posedge clk) reset_n <= 1'b1;
        t_perm;
        t_timed;
        t_expire;
        t_misc;
        end_of_test;
    end
endmodule : utdc_ctrl_tb
